// >>> design/pvc_pkg.sv
// Package for the process-value conditioning block: register map,
// field positions, reset values and fixed numeric constants.
// Assumes a 50 MHz system clock and percent values in 0.01 % steps.
package pvc_pkg;

    // Clock and timing
    localparam int CLK_KHZ = 50_000;
    localparam int ACC_PERIOD_MS = 1000;
    localparam int ACC_PERIOD_CYC = ACC_PERIOD_MS * CLK_KHZ;

    // Register word addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ZERO = 8'h01;
    localparam logic [7:0] ADDR_SPAN = 8'h02;
    localparam logic [7:0] ADDR_SPPOS = 8'h03;
    localparam logic [7:0] ADDR_SCMIN = 8'h04;
    localparam logic [7:0] ADDR_SCMAX = 8'h05;
    localparam logic [7:0] ADDR_SENLO = 8'h06;
    localparam logic [7:0] ADDR_SENHI = 8'h07;
    localparam logic [7:0] ADDR_INRLIM = 8'h08;
    localparam logic [7:0] ADDR_INRTIME = 8'h09;
    localparam logic [7:0] ADDR_STAT = 8'h0A;
    localparam logic [7:0] ADDR_ACCTOT = 8'h0B;
    localparam logic [7:0] ADDR_RATE = 8'h0C;
    localparam logic [7:0] ADDR_LASTPV = 8'h0D;

    // Control register fields
    localparam int CTL_BRKHIGH = 0;
    localparam int CTL_KINDDC = 1;
    localparam int CTL_LIMCHK = 2;
    localparam int CTL_UNIV = 3;
    localparam int CTL_SQRTEN = 4;
    localparam int CTL_MV100 = 5;
    localparam int CTL_RANGE_LO = 6;
    localparam int CTL_SPEN = 8;
    localparam int CTL_STEP_LO = 9;
    localparam int CTL_CJMASK_LO = 11;

    // Range codes for the 100 mV variant
    localparam logic [1:0] RANGE_1_5V = 2'h1;
    localparam logic [1:0] RANGE_4_40MA = 2'h2;

    // Reset values
    localparam logic [15:0] CTRL_RST = 16'h1800;
    localparam logic [15:0] SPAN_RST = 16'h4000;
    localparam logic [15:0] SCMAX_RST = 16'h2710;
    localparam logic [15:0] SENLO_RST = 16'h8000;
    localparam logic [15:0] SENHI_RST = 16'h7FFF;
    localparam logic [15:0] INRLIM_RST = 16'h2710;
    localparam logic [15:0] INRTIME_RST = 16'h000A;

    // Numeric constants, percent in 0.01 % steps
    localparam int GAIN_FRAC = 14;
    localparam int PCT_FULL = 10000;
    localparam int BRK_HIGH_PCT = 11500;
    localparam int BRK_LOW_PCT = -1500;
    localparam int TEMP_LIM_DIGITS = 20;
    localparam int DC_LIM_LO_PCT = -500;
    localparam int DC_LIM_HI_PCT = 10500;
    localparam int SQRT_LIN_PCT = 700;
    localparam int LIN_MUL = 14629;
    localparam int LIN_SHIFT = 10;
    localparam int INR_LOW_PCT = 200;
    localparam int ACC_MAX = 9999;
    localparam int ACC_WRAP = 10000;

endpackage

// >>> design/pvc_conditioner.sv
// Process-value conditioning for a multi-channel isolated input module:
// break and range errors, cold-junction fault, square root, inrush
// limit, zero/span correction and pulse stepdown into an accumulator.
// Assumes samples arrive one channel at a time, synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Break drives PV of temperature inputs to 115% or -15%
// - Universal variant reports break as input error
// - Temperature error beyond sensor limits plus 20
// - DC error below -5% or above 105%
// - Cold-junction fault flags, stores uncompensated value
// - Any enabled cold-junction sensor fault stops all compensation
// - Square-root mode stores root of input
// - Linear characteristic at 7% output or less
// - Root only when scaling max exceeds min
// - Universal variant: root only for DC inputs
// - 100 mV variant: root only two ranges
// - Clamp PV temporarily when rising from 2%
// - Zero adjustment adds constant offset
// - Span adjustment is gain about minimum
// - Offset and gain re-read live, no restart
// - Optional adjustment about a specified point
// - Pulse stepdown of 1/10, 1/100, 1/1000
// - Stepdown only feeds accumulator, not rate
// - Add stepped count each accumulation period
// - Total wraps above 9999 back to zero
module pvc_conditioner
    import pvc_pkg::*;
#(
    parameter int NCH = 4,
    parameter int ACC_PERIOD = ACC_PERIOD_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdData,
    // Sample input from the converter front end
    input wire logic smpValid,
    input wire logic [$clog2(NCH)-1:0] smpChan,
    input wire logic signed [15:0] smpPct,
    input wire logic signed [15:0] smpDigits,
    input wire logic signed [15:0] smpCj,
    input wire logic smpBreak,
    input wire logic [1:0] cjFault,
    // Pulse input
    input wire logic pulseIn,
    // Process value output
    output logic signed [15:0] pvData,
    output logic pvValid,
    output logic [$clog2(NCH)-1:0] pvChan,
    // Flags and counters
    output logic [NCH-1:0] discFlags,
    output logic [NCH-1:0] inErrFlags,
    output logic [NCH-1:0] cjFlags,
    output logic [13:0] accTotal,
    output logic [15:0] pulseRate
);

    localparam int CHW = $clog2(NCH);

    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] zero;
        logic [15:0] span;
        logic [15:0] spPos;
        logic [15:0] scMin;
        logic [15:0] scMax;
        logic [15:0] senLo;
        logic [15:0] senHi;
        logic [15:0] inrLim;
        logic [15:0] inrTime;
        logic [NCH-1:0] disc;
        logic [NCH-1:0] err;
        logic [NCH-1:0] cj;
        logic [NCH-1:0] inrLow;
        logic [NCH-1:0][15:0] inrTmr;
        logic [15:0] pv;
        logic pvValid;
        logic [CHW-1:0] pvChan;
        logic [15:0] rdData;
        logic [9:0] pre;
        logic [13:0] stepCnt;
        logic [15:0] rateCnt;
        logic [15:0] rate;
        logic [13:0] accTot;
        logic [31:0] perCnt;
    } pvc_state_s;

    pvc_state_s st_r;
    pvc_state_s st_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [15:0] isqrt(input logic [31:0] v);
        logic [15:0] r;
        logic [15:0] c;
        r = '0;
        for (int i = 15; i >= 0; i--) begin
            c = r | (16'h0001 << i);
            if ({16'h0000, c} * {16'h0000, c} <= {32'h0000_0000, v}) begin
                r = c;
            end
        end
        return r;
    endfunction

    function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
        if (v > 48'sh0000_0000_7FFF) begin
            return 16'sh7FFF;
        end else if (v < -48'sh0000_0000_8000) begin
            return -16'sh8000;
        end
        return v[15:0];
    endfunction

    function automatic logic [9:0] stepRatio(input logic [1:0] sel);
        unique case (sel)
            2'h0: return 10'h001;
            2'h1: return 10'h00A;
            2'h2: return 10'h064;
            2'h3: return 10'h3E8;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    logic cjAny;
    logic sqrtOk;
    logic limErr;
    logic signed [47:0] comp;
    logic signed [47:0] lin;
    logic signed [47:0] base;
    logic signed [47:0] adj;
    logic signed [15:0] pvCalc;
    logic [15:0] root;
    logic [31:0] xPos;
    logic [15:0] tmrNext;
    logic [9:0] ratio;
    logic [13:0] stepNow;
    logic [14:0] accSum;
    logic [1:0] rangeSel;

    always_comb begin
        st_nxt = st_r;
        rangeSel = st_r.ctrl[CTL_RANGE_LO +: 2];
        ratio = stepRatio(st_r.ctrl[CTL_STEP_LO +: 2]);
        root = '0;
        xPos = '0;
        lin = '0;
        tmrNext = '0;
        stepNow = st_r.stepCnt;
        accSum = '0;

        // Fault on any enabled cold-junction sensor stops compensation everywhere
        cjAny = |(cjFault & st_r.ctrl[CTL_CJMASK_LO +: 2]);
        comp = 48'(smpPct) + (cjAny ? 48'sd0 : 48'(smpCj));

        // Square root permitted only for DC kinds with valid scaling and range
        sqrtOk = st_r.ctrl[CTL_SQRTEN] && st_r.ctrl[CTL_KINDDC]
            && ($signed(st_r.scMax) > $signed(st_r.scMin))
            && (!st_r.ctrl[CTL_MV100] || rangeSel == RANGE_1_5V
                || rangeSel == RANGE_4_40MA);
        if (sqrtOk) begin
            xPos = (comp < 0) ? 32'h0000_0000 : 32'(comp[15:0]);
            root = isqrt(xPos * 32'(PCT_FULL));
            lin = 48'($signed({1'b0, xPos}) * LIN_MUL) >>> LIN_SHIFT;
            if (root <= 16'(SQRT_LIN_PCT)) begin
                comp = lin;
            end else begin
                comp = 48'(root);
            end
        end

        // Zero offset plus gain about range minimum or specified point
        base = st_r.ctrl[CTL_SPEN] ? 48'($signed(st_r.spPos)) : 48'sd0;
        adj = base + (((comp - base) * 48'($signed(st_r.span))) >>> GAIN_FRAC)
            + 48'($signed(st_r.zero));
        pvCalc = sat16(adj);

        // Inrush limit, timed in samples of the same channel
        tmrNext = (st_r.inrTmr[smpChan] != 16'h0000) ? st_r.inrTmr[smpChan] - 16'h0001
            : 16'h0000;
        if (st_r.inrLow[smpChan] && pvCalc >= 16'(INR_LOW_PCT)) begin
            tmrNext = st_r.inrTime;
        end
        if (tmrNext != 16'h0000 && pvCalc > $signed(st_r.inrLim)) begin
            pvCalc = st_r.inrLim;
        end

        // Break overrides the value for temperature inputs
        if (smpBreak && !st_r.ctrl[CTL_KINDDC]) begin
            pvCalc = st_r.ctrl[CTL_BRKHIGH] ? 16'(BRK_HIGH_PCT) : 16'(BRK_LOW_PCT);
        end

        if (st_r.ctrl[CTL_KINDDC]) begin
            limErr = (smpPct < 16'(DC_LIM_LO_PCT)) || (smpPct > 16'(DC_LIM_HI_PCT));
        end else begin
            limErr = (32'(smpDigits) > 32'($signed(st_r.senHi)) + TEMP_LIM_DIGITS)
                || (32'(smpDigits) < 32'($signed(st_r.senLo)) - TEMP_LIM_DIGITS);
        end
        limErr = limErr && st_r.ctrl[CTL_LIMCHK];

        st_nxt.pvValid = 1'b0;
        if (smpValid) begin
            st_nxt.pv = pvCalc;
            st_nxt.pvValid = 1'b1;
            st_nxt.pvChan = smpChan;
            st_nxt.inrTmr[smpChan] = tmrNext;
            st_nxt.inrLow[smpChan] = pvCalc < 16'(INR_LOW_PCT);
            // Flags are levels: each follows the latest sample of its channel
            st_nxt.disc[smpChan] = smpBreak && !st_r.ctrl[CTL_UNIV]
                && !st_r.ctrl[CTL_KINDDC];
            st_nxt.err[smpChan] = limErr || (smpBreak && st_r.ctrl[CTL_UNIV]);
            st_nxt.cj[smpChan] = cjAny && !st_r.ctrl[CTL_KINDDC];
        end

        ////////////////////////////////////////////////////////////////////
        // Pulse stepdown and accumulation

        if (pulseIn) begin
            if (st_r.pre + 10'h001 >= ratio) begin
                st_nxt.pre = 10'h000;
                if (st_r.stepCnt < 14'(ACC_MAX)) begin
                    stepNow = st_r.stepCnt + 14'h0001;
                end
            end else begin
                st_nxt.pre = st_r.pre + 10'h001;
            end
        end
        st_nxt.stepCnt = stepNow;
        if (pulseIn && st_r.rateCnt != 16'hFFFF) begin
            st_nxt.rateCnt = st_r.rateCnt + 16'h0001;
        end

        if (st_r.perCnt >= 32'(ACC_PERIOD - 1)) begin
            st_nxt.perCnt = 32'h0000_0000;
            accSum = {1'b0, st_r.accTot} + {1'b0, st_r.stepCnt};
            st_nxt.accTot = (accSum > 15'(ACC_MAX)) ? 14'(accSum - 15'(ACC_WRAP))
                : accSum[13:0];
            st_nxt.rate = st_r.rateCnt;
            // A pulse in the closing cycle counts into the next period
            st_nxt.stepCnt = (pulseIn && stepNow != st_r.stepCnt) ? 14'h0001 : 14'h0000;
            st_nxt.rateCnt = pulseIn ? 16'h0001 : 16'h0000;
        end else begin
            st_nxt.perCnt = st_r.perCnt + 32'h0000_0001;
        end

        ////////////////////////////////////////////////////////////////////
        // Register writes take effect on the next sample

        if (regWr) begin
            unique case (regAddr)
                ADDR_CTRL: st_nxt.ctrl = regWrData;
                ADDR_ZERO: st_nxt.zero = regWrData;
                ADDR_SPAN: st_nxt.span = regWrData;
                ADDR_SPPOS: st_nxt.spPos = regWrData;
                ADDR_SCMIN: st_nxt.scMin = regWrData;
                ADDR_SCMAX: st_nxt.scMax = regWrData;
                ADDR_SENLO: st_nxt.senLo = regWrData;
                ADDR_SENHI: st_nxt.senHi = regWrData;
                ADDR_INRLIM: st_nxt.inrLim = regWrData;
                ADDR_INRTIME: st_nxt.inrTime = regWrData;
                default: ;
            endcase
        end

        st_nxt.rdData = 16'h0000;
        if (regRd) begin
            unique case (regAddr)
                ADDR_CTRL: st_nxt.rdData = st_r.ctrl;
                ADDR_ZERO: st_nxt.rdData = st_r.zero;
                ADDR_SPAN: st_nxt.rdData = st_r.span;
                ADDR_SPPOS: st_nxt.rdData = st_r.spPos;
                ADDR_SCMIN: st_nxt.rdData = st_r.scMin;
                ADDR_SCMAX: st_nxt.rdData = st_r.scMax;
                ADDR_SENLO: st_nxt.rdData = st_r.senLo;
                ADDR_SENHI: st_nxt.rdData = st_r.senHi;
                ADDR_INRLIM: st_nxt.rdData = st_r.inrLim;
                ADDR_INRTIME: st_nxt.rdData = st_r.inrTime;
                ADDR_STAT: st_nxt.rdData = 16'({st_r.cj[3:0], st_r.err[3:0], st_r.disc[3:0]});
                ADDR_ACCTOT: st_nxt.rdData = {2'b00, st_r.accTot};
                ADDR_RATE: st_nxt.rdData = st_r.rate;
                ADDR_LASTPV: st_nxt.rdData = st_r.pv;
                default: st_nxt.rdData = 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
            st_r.ctrl <= CTRL_RST;
            st_r.span <= SPAN_RST;
            st_r.scMax <= SCMAX_RST;
            st_r.senLo <= SENLO_RST;
            st_r.senHi <= SENHI_RST;
            st_r.inrLim <= INRLIM_RST;
            st_r.inrTime <= INRTIME_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdData = st_r.rdData;
    assign pvData = st_r.pv;
    assign pvValid = st_r.pvValid;
    assign pvChan = st_r.pvChan;
    assign discFlags = st_r.disc;
    assign inErrFlags = st_r.err;
    assign cjFlags = st_r.cj;
    assign accTotal = st_r.accTot;
    assign pulseRate = st_r.rate;

endmodule

`default_nettype wire

// >>> sim/pvc_conditioner_assertions.sv
// Port-level checker for pvc_conditioner.
// Bound to every instance; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pvc_conditioner_assertions
    import pvc_pkg::*;
#(
    parameter int NCH = 4,
    parameter int ACC_PERIOD = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Observed ports
    input wire logic regRd,
    input wire logic [15:0] regRdData,
    input wire logic smpValid,
    input wire logic [$clog2(NCH)-1:0] smpChan,
    input wire logic signed [15:0] pvData,
    input wire logic pvValid,
    input wire logic [$clog2(NCH)-1:0] pvChan,
    input wire logic [NCH-1:0] discFlags,
    input wire logic [NCH-1:0] inErrFlags,
    input wire logic [13:0] accTotal,
    input wire logic [15:0] pulseRate
);
    ////////////////////////////////////////
    int cnt_r;
    logic [NCH-1:0] others;
    // Mirrors the accumulation period counter from reset release
    always_ff @(posedge clk) begin
        cnt_r <= (rst || cnt_r == ACC_PERIOD - 1) ? 0 : cnt_r + 1;
    end
    assign others = ~(NCH'(1) << pvChan);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_pvTime; smpValid |=> pvValid && pvChan == $past(smpChan); endproperty
    a_pvTime: assert property (p_pvTime) else $error("pv late");
    property p_pvHold; !smpValid |=> !pvValid && $stable(pvData); endproperty
    a_pvHold: assert property (p_pvHold) else $error("pv moved");
    property p_rdIdle; !regRd |=> regRdData == 16'h0000; endproperty
    a_rdIdle: assert property (p_rdIdle) else $error("read data stuck");
    property p_brk; pvValid && discFlags[pvChan] |-> pvData inside {16'h2CEC, 16'hFA24}; endproperty
    a_brk: assert property (p_brk) else $error("break value");
    property p_accMax; accTotal <= 14'h270F; endproperty
    a_accMax: assert property (p_accMax) else $error("total range");
    property p_accHold;
        cnt_r != ACC_PERIOD - 1 |=> $stable(accTotal) && $stable(pulseRate);
    endproperty
    a_accHold: assert property (p_accHold) else $error("total off period");
    property p_flagOne;
        smpValid |=> (((discFlags ^ $past(discFlags)) | (inErrFlags ^ $past(inErrFlags)))
            & others) == '0;
    endproperty
    a_flagOne: assert property (p_flagOne) else $error("other flags moved");
    property p_flagHold; !smpValid |=> $stable(discFlags) && $stable(inErrFlags); endproperty
    a_flagHold: assert property (p_flagHold) else $error("flags moved");
endmodule
bind pvc_conditioner pvc_conditioner_assertions #(.NCH(NCH), .ACC_PERIOD(ACC_PERIOD)) chk_u (
    .clk, .rst, .regRd, .regRdData, .smpValid, .smpChan, .pvData, .pvValid, .pvChan,
    .discFlags, .inErrFlags, .accTotal, .pulseRate);
`default_nettype wire

// >>> sim/pvc_pulse_src.sv
// Pulse sensor model: sends num pulses, one every other cycle.
// Assumes go is a one-cycle request while busy is low.
`timescale 1ns/1ps
`default_nettype none
module pvc_pulse_src (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Request
    input wire logic go,
    input wire logic [15:0] num,
    // Pulse line and status
    output logic pulseIn,
    output logic busy
);
    ////////////////////////////////////////
    logic [16:0] left_r;
    always_ff @(posedge clk) begin
        if (rst || go) begin
            left_r <= rst ? 17'h0_0000 : {num, 1'b0};
            pulseIn <= 1'b0;
        end else begin
            pulseIn <= left_r[0];
            left_r <= left_r - 17'(left_r != 0);
        end
    end
    assign busy = (left_r != 0) || pulseIn;
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for pvc_conditioner with a pulse source model.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import pvc_pkg::*;
;
    ////////////////////////////////////////
    localparam int AP = 64;
    logic clk, rst, regWr, regRd, smpValid, smpBreak, pulseIn, pvValid, go, busy;
    logic [7:0] regAddr;
    logic [15:0] regWrData, regRdData, pulseRate, num, ctrl;
    logic [1:0] smpChan, cjFault, pvChan;
    logic signed [15:0] smpPct, smpDigits, smpCj, pvData;
    logic [3:0] discFlags, inErrFlags, cjFlags;
    logic [13:0] accTotal;
    int zero, span, sppos, scmin, scmax, errTotal, nTests, cyc, i, j, p, c, f;
    logic [15:0] rv [10] = '{CTRL_RST, 16'h0000, SPAN_RST, 16'h0000, 16'h0000, SCMAX_RST,
        SENLO_RST, SENHI_RST, INRLIM_RST, INRTIME_RST};
    int lt [8] = '{1020, 1021, -20, -21, 10500, 10501, -500, -501};
    logic [15:0] ct [11] = '{16'h0012, 16'h0012, 16'h0012, 16'h0012, 16'h0012, 16'h001A,
        16'h0018, 16'h0032, 16'h0072, 16'h00B2, 16'h00F2};
    int px [11] = '{2500, 10, 49, 50, 2500, 2500, 2500, 2500, 2500, 2500, 2500};
    int nn [4] = '{10005, 125, 350, 2500};
    int ea [4] = '{5, 12, 3, 2};
    pvc_conditioner #(.NCH(4), .ACC_PERIOD(AP)) dut_u (.clk, .rst, .regAddr, .regWrData,
        .regWr, .regRd, .regRdData, .smpValid, .smpChan, .smpPct, .smpDigits, .smpCj,
        .smpBreak, .cjFault, .pulseIn, .pvData, .pvValid, .pvChan, .discFlags, .inErrFlags,
        .cjFlags, .accTotal, .pulseRate);
    pvc_pulse_src src_u (.clk, .rst, .go, .num, .pulseIn, .busy);
    always #10 clk = ~clk;
    task automatic summarize();
        if (errTotal == 0 && nTests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            errTotal++;
            summarize();
        end
    end
    task automatic chk(logic [31:0] s, logic [31:0] e);
        nTests++;
        if (s !== e) begin
            errTotal++;
            $display("[FAIL] %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic wr(logic [7:0] a, int d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d[15:0];
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        case (a)
            ADDR_CTRL: ctrl = d[15:0];
            ADDR_ZERO: zero = d;
            ADDR_SPAN: span = d;
            ADDR_SPPOS: sppos = d;
            ADDR_SCMIN: scmin = d;
            default: ;
        endcase
    endtask
    task automatic rd(logic [7:0] a, logic [15:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 chk(regRdData, e);
    endtask
    task automatic smp(int ch, int pc, int d, int cj, int b);
        @(posedge clk);
        smpValid <= 1'b1;
        smpChan <= ch[1:0];
        smpPct <= pc[15:0];
        smpDigits <= d[15:0];
        smpCj <= cj[15:0];
        smpBreak <= b[0];
        @(posedge clk);
        smpValid <= 1'b0;
        #1;
    endtask
    function automatic int expPv(int v, int b);
        int y;
        int base;
        if (ctrl[4] && ctrl[1] && scmax > scmin && (!ctrl[5] || ctrl[7:6] inside {1, 2})) begin
            v = v < 0 ? 0 : v;
            y = 0;
            while ((y + 1) * (y + 1) <= v * 10000) y++;
            v = y <= 700 ? (v * 14629) >>> 10 : y;
        end
        base = ctrl[8] ? sppos : 0;
        v = base + (((v - base) * span) >>> 14) + zero;
        return (b != 0 && !ctrl[1]) ? (ctrl[0] ? 11500 : -1500) : v;
    endfunction
    initial begin
        {clk, regWr, regRd, smpValid, smpBreak, go, regAddr, regWrData, num} = '0;
        {smpChan, cjFault, smpPct, smpDigits, smpCj} = '0;
        {zero, sppos, scmin, errTotal, nTests, cyc} = '0;
        rst = 1'b1;
        ctrl = CTRL_RST;
        span = 16384;
        scmax = 10000;
        void'($urandom(82));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 16; i++) rd(8'(i), i < 10 ? rv[i] : 16'h0000);
        wr(ADDR_INRTIME, 0);
        for (i = 0; i < 40; i++) begin
            c = $urandom & 16'h1809;
            wr(ADDR_CTRL, c);
            cjFault <= 2'($urandom);
            p = $urandom_range(9000);
            j = $urandom_range(3);
            smp(j, p, 0, c[7:0], p % 2);
            f = |(cjFault & ctrl[12:11]);
            chk(pvData, expPv(p + (f != 0 ? 0 : c[7:0]), p % 2));
            chk(cjFlags[j], f);
            chk(discFlags[j], p % 2 == 1 && !ctrl[3]);
            chk(inErrFlags[j], p % 2 == 1 && ctrl[3]);
        end
        cjFault <= 2'h0;
        wr(ADDR_SENLO, 0);
        wr(ADDR_SENHI, 1000);
        for (j = 0; j < 8; j++) begin
            wr(ADDR_CTRL, j < 4 ? 16'h0004 : 16'h0006);
            smp(1, j < 4 ? 500 : lt[j], lt[j], 0, 0);
            chk(inErrFlags[1], j % 2);
        end
        wr(ADDR_SPPOS, 5000);
        for (i = 0; i < 10; i++) begin
            wr(ADDR_CTRL, i % 2 ? 16'h0102 : 16'h0002);
            wr(ADDR_ZERO, $urandom_range(600) - 300);
            wr(ADDR_SPAN, $urandom_range(24576, 8192));
            p = $urandom_range(9000);
            smp(0, p, 0, 0, 0);
            chk(pvData, expPv(p, 0));
        end
        wr(ADDR_ZERO, 0);
        wr(ADDR_SPAN, 16384);
        for (i = 0; i < 11; i++) begin
            wr(ADDR_SCMIN, i == 4 ? 20000 : 0);
            wr(ADDR_CTRL, ct[i]);
            smp(2, px[i], 0, 0, 0);
            chk(pvData, expPv(px[i], 0));
        end
        wr(ADDR_CTRL, 16'h0002);
        wr(ADDR_INRLIM, 5000);
        wr(ADDR_INRTIME, 3);
        smp(3, 100, 0, 0, 0);
        for (i = 0; i < 6; i++) begin
            smp(3, 8000, 0, 0, 0);
            if (i == 0 || i == 5) chk(pvData, i == 0 ? 5000 : 8000);
        end
        for (j = 0; j < 4; j++) begin
            rst <= 1'b1;
            repeat (2) @(posedge clk);
            rst <= 1'b0;
            wr(ADDR_CTRL, j << 9);
            num <= nn[j][15:0];
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            repeat (3 * AP) @(posedge clk);
            chk(pulseRate, AP / 2);
            for (i = 0; i < 30000 && busy; i++) @(posedge clk);
            repeat (3 * AP) @(posedge clk);
            chk(accTotal, ea[j]);
            rd(ADDR_ACCTOT, 16'(ea[j]));
        end
        summarize();
    end
endmodule
`default_nettype wire
